// [design/stmr_pkg.sv]
package stmr_pkg;
	// ----------------------------------------
	// Message format
	// ----------------------------------------
	localparam logic [3:0] MSG_REG_ACCESS = 4'h8;
	localparam logic [3:0] MSG_READ_UPPER = 4'h0;
	localparam logic [3:0] MSG_READ_SUB = 4'h0;

	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [3:0] ADDR_VERSION_ID = 4'h0;
	localparam logic [3:0] ADDR_OPERATING_CONFIG = 4'h1;
	localparam logic [3:0] ADDR_LOOPBACK_CONTROL = 4'h2;
	localparam logic [3:0] ADDR_CHANNEL_SWITCHING = 4'h3;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_OPERATING_CONFIG = 8'h00;
	localparam logic [7:0] RST_LOOPBACK_CONTROL = 8'h00;
	localparam logic [7:0] RST_CHANNEL_SWITCHING = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CFG_EXCHANGE_MODE = 7;
	localparam int CFG_MULTI_MEANING = 6;
	localparam int CFG_SQ_HANDLING = 5;
	localparam int CFG_CV_REPORT = 4;
	localparam int CFG_LOOP_TRANSP = 3;
	localparam int CFG_SM_SWAP = 2;
	localparam int CFG_AUX_PORT = 1;
	localparam int CFG_MF_DISABLE = 0;
	localparam int LBK_ASYNC_WAKE = 7;
	localparam int LBK_LINE_B1 = 6;
	localparam int LBK_LINE_B2 = 5;
	localparam int LBK_FULL_ANALOG = 4;
	localparam int LBK_HOST_B1 = 3;
	localparam int LBK_HOST_B2 = 2;
	localparam int LBK_B_SWAP = 1;
	localparam int CHS_B1_RELOC = 7;
	localparam int CHS_B2_RELOC = 6;
	localparam int CHS_D_RELOC = 5;
	localparam int CHS_B1_DIR = 4;
	localparam int CHS_B2_DIR = 3;
	localparam int CHS_CMD_HANDLING = 2;
	localparam int CHS_D_PROTO_LSB = 0;

	// ----------------------------------------
	// Monitor slot timing, in data bits from frame start
	// ----------------------------------------
	localparam logic [7:0] MON_SLOT_BIT = 8'h10;
	localparam logic [7:0] MON_VALID_BIT = 8'h18;

	typedef enum logic [1:0] {
		MODE_TE = 2'b00,
		MODE_NT = 2'b01,
		MODE_LTT = 2'b10,
		MODE_LTS = 2'b11
	} stmr_mode_t;

	typedef enum logic [1:0] {
		AUX_IO_SPECIFIC = 2'b00,
		AUX_IO_STANDARD = 2'b01,
		AUX_MICRO = 2'b10
	} stmr_aux_t;
endpackage : stmr_pkg

// [design/stmr_mon_if.sv]
`timescale 1ns/1ps
interface stmr_mon_if;
	logic [7:0] rx_byte;
	logic rx_valid;
	logic [7:0] tx_byte;
	logic tx_req;
	logic tx_ack;
	modport engine (output rx_byte, output rx_valid, output tx_ack, input tx_byte, input tx_req);
	modport msg (input rx_byte, input rx_valid, input tx_ack, output tx_byte, output tx_req);
endinterface : stmr_mon_if

// [design/stmr_slot_engine.sv]
`timescale 1ns/1ps
module stmr_slot_engine (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic dcl_s,
	input wire logic fsc_s,
	input wire logic din_s,
	output logic dout,
	output logic dout_oe,
	stmr_mon_if.engine mon
);
	import stmr_pkg::*;

	typedef struct packed {
		logic dcl_d;
		logic fsc_d;
		logic half;
		logic [7:0] bit_cnt;
		logic [7:0] rx_sh;
		logic [7:0] rx_byte;
		logic rx_valid;
		logic [7:0] tx_sh;
		logic busy;
		logic tx_ack;
		logic dout;
		logic dout_oe;
	} stmr_eng_t;

	stmr_eng_t r_reg;
	stmr_eng_t r_next;

	always_comb begin
		r_next = r_reg;
		r_next.dcl_d = dcl_s;
		r_next.fsc_d = fsc_s;
		r_next.rx_valid = 1'b0;
		r_next.tx_ack = 1'b0;
		if (fsc_s && !r_reg.fsc_d) begin
			r_next.bit_cnt = 8'h00;
			r_next.half = 1'b0;
			// A new byte only starts on a frame boundary so it never splits
			if (mon.tx_req && !r_reg.busy && !r_reg.tx_ack) begin
				r_next.tx_sh = mon.tx_byte;
				r_next.busy = 1'b1;
			end
		end else if (dcl_s && !r_reg.dcl_d) begin
			r_next.half = ~r_reg.half;
			if (!r_reg.half) begin
				if (r_reg.bit_cnt >= MON_SLOT_BIT && r_reg.bit_cnt < MON_VALID_BIT) begin
					r_next.rx_sh = {r_reg.rx_sh[6:0], din_s};
				end
				// Valid marker is active low
				if (r_reg.bit_cnt == MON_VALID_BIT && !din_s) begin
					r_next.rx_byte = r_reg.rx_sh;
					r_next.rx_valid = 1'b1;
				end
			end else begin
				if (r_reg.bit_cnt != 8'hFF) begin
					r_next.bit_cnt = r_reg.bit_cnt + 8'h01;
				end
				if (r_reg.bit_cnt >= MON_SLOT_BIT && r_reg.bit_cnt < MON_VALID_BIT) begin
					r_next.tx_sh = {r_reg.tx_sh[6:0], 1'b0};
				end
				if (r_reg.bit_cnt == MON_VALID_BIT && r_reg.busy) begin
					r_next.busy = 1'b0;
					r_next.tx_ack = 1'b1;
				end
			end
		end
		r_next.dout_oe = r_next.busy && r_next.bit_cnt >= MON_SLOT_BIT
			&& r_next.bit_cnt <= MON_VALID_BIT;
		r_next.dout = (r_next.bit_cnt == MON_VALID_BIT) ? 1'b0 : r_next.tx_sh[7];
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign dout = r_reg.dout;
	assign dout_oe = r_reg.dout_oe;
	assign mon.rx_byte = r_reg.rx_byte;
	assign mon.rx_valid = r_reg.rx_valid;
	assign mon.tx_ack = r_reg.tx_ack;
endmodule : stmr_slot_engine

// [design/stmr_regs.sv]
// Operation
// (R1) Registers reached only by monitor messages
// (R2) Read request: 80h, then 0h and address
// (R3) Read answer: 8h plus address, then data
// (R4) Fixed read-only version code register
// (R5) Exchange bit picks trunk, honoured if strap high
// (R6) Line/network modes: multi-meaning bit sets timing recovery
// (R7) Trunk mode: multi-meaning bit picks wander limit
// (R8) Terminal mode: multi-meaning bit picks converter clock
// (R9) Non-auto S/Q: report on change, no S2
// (R10) Transparent S/Q: report every multiframe, needs multiframing
// (R11) Code violation indication when reporting enabled
// (R12) Loop transparency, default depends on mode
// (R13) State machine swap between line and network termination
// (R14) Aux port mode bit, variant from outside
// (R15) Multiframe disable writes; read shows sync state
// (R16) Async wake-up timing only with network machine
// (R17) Line-side B loops in line/network modes
// (R18) Full analog loop, also by command
// (R19) Host-side B loops, both allowed together
// (R20) B swap when both host loops set
// (R21) Relocate B1, B2, D into channel 0
// (R22) Per-channel data pin direction swap
// (R23) Commands from register only when handling set
// (R24) D-channel access protocol select
`timescale 1ns/1ps
module stmr_regs #(
	parameter logic [7:0] VERSION_CODE = 8'h5A
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic dcl,
	input wire logic fsc,
	input wire logic host_data_in_pin,
	output logic host_data_out_pin,
	output logic host_data_out_oe,
	input wire stmr_pkg::stmr_mode_t strap_mode,
	input wire logic mode_strap_pin,
	input wire logic mf_sync_established,
	input wire logic analog_loop_command,
	input wire logic aux_io_variant,
	input wire logic code_violation_detected,
	input wire logic wander_exceeded,
	input wire logic [3:0] sq_rx_data,
	input wire logic multiframe_tick,
	output stmr_pkg::stmr_mode_t active_mode,
	output logic nt_state_machine,
	output logic adaptive_timing,
	output logic wander_limit_50us,
	output logic conv_clk_16k,
	output logic sq_report,
	output logic [3:0] sq_report_data,
	output logic sq_s2_available,
	output logic code_violation_indication,
	output logic wander_warning_indication,
	output logic loop_transparency,
	output logic line_side_b1_loop,
	output logic line_side_b2_loop,
	output logic full_analog_loop,
	output logic host_side_b1_loop,
	output logic host_side_b2_loop,
	output logic b_channel_swap,
	output logic b1_relocate,
	output logic b2_relocate,
	output logic d_relocate,
	output logic b1_direction_swap,
	output logic b2_direction_swap,
	output logic command_channel_handling,
	output logic [1:0] d_access_protocol,
	output stmr_pkg::stmr_aux_t aux_port_mode,
	output logic async_wakeup_timing,
	output logic multiframe_enable
);
	import stmr_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WDATA = 3'b001,
		ST_RADDR = 3'b010,
		ST_RESP_HDR = 3'b011,
		ST_RESP_DATA = 3'b100
	} stmr_state_t;

	typedef struct packed {
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic [1:0] strap_cnt;
		stmr_state_t state;
		logic [3:0] addr;
		logic [7:0] tx_byte;
		logic tx_req;
		logic [7:0] operating_config;
		logic [7:0] loopback_control;
		logic [7:0] channel_switching;
		logic [3:0] sq_last;
		logic sq_report;
		logic [3:0] sq_report_data;
		logic cv_ind;
		logic wander_ind;
		stmr_mode_t mode;
		logic nt_sm;
		logic adaptive;
		logic wander50;
		logic clk16;
		logic sq_s2;
		logic lp;
		logic lb1;
		logic lb2;
		logic full;
		logic hb1;
		logic hb2;
		logic bswap;
		logic [7:0] chs_out;
		stmr_aux_t aux;
		logic async_wake;
		logic mf_en;
	} stmr_state_reg_t;

	stmr_state_reg_t r_reg;
	stmr_state_reg_t r_next;

	stmr_mon_if mon ();

	logic dcl_s;
	logic fsc_s;
	logic din_s;
	logic mode_pin_s;
	stmr_mode_t strap_s;
	logic [7:0] read_data;
	logic line_nt_mode;
	stmr_mode_t eff_mode;

	assign dcl_s = r_reg.sync2[5];
	assign fsc_s = r_reg.sync2[4];
	assign din_s = r_reg.sync2[3];
	assign mode_pin_s = r_reg.sync2[2];
	assign strap_s = stmr_mode_t'(r_reg.sync2[1:0]);

	// ----------------------------------------
	// Monitor slot transport
	// ----------------------------------------
	stmr_slot_engine u_engine (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.dcl_s(dcl_s),
		.fsc_s(fsc_s),
		.din_s(din_s),
		.dout(host_data_out_pin),
		.dout_oe(host_data_out_oe),
		.mon(mon.engine)
	);

	assign mon.tx_byte = r_reg.tx_byte;
	assign mon.tx_req = r_reg.tx_req;

	// ----------------------------------------
	// Read multiplexer
	// ----------------------------------------
	always_comb begin
		read_data = 8'h00;
		case (r_reg.addr)
			ADDR_VERSION_ID: begin
				read_data = VERSION_CODE; // (R4)
			end
			ADDR_OPERATING_CONFIG: begin
				read_data = r_reg.operating_config;
				read_data[CFG_MF_DISABLE] = mf_sync_established; // (R15)
			end
			ADDR_LOOPBACK_CONTROL: begin
				read_data = r_reg.loopback_control;
			end
			ADDR_CHANNEL_SWITCHING: begin
				read_data = r_reg.channel_switching;
			end
			default: begin
				read_data = 8'h00;
			end
		endcase
	end

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	always_comb begin
		eff_mode = strap_s;
		// The exchange bit only toggles between the two line-termination flavours
		if (mode_pin_s && (strap_s == MODE_LTS || strap_s == MODE_LTT)) begin
			eff_mode = r_reg.operating_config[CFG_EXCHANGE_MODE] ? MODE_LTT : MODE_LTS; // (R5)
		end
		line_nt_mode = (eff_mode == MODE_LTS) || (eff_mode == MODE_NT);
	end

	always_comb begin
		r_next = r_reg;
		r_next.sync1 = {dcl, fsc, host_data_in_pin, mode_strap_pin, strap_mode};
		r_next.sync2 = r_reg.sync1;
		r_next.sq_report = 1'b0;
		r_next.cv_ind = 1'b0;
		r_next.wander_ind = 1'b0;

		// Straps settle through the synchroniser before the default is taken
		if (r_reg.strap_cnt != 2'd3) begin
			r_next.strap_cnt = r_reg.strap_cnt + 2'd1;
		end
		if (r_reg.strap_cnt == 2'd2) begin
			r_next.operating_config[CFG_LOOP_TRANSP] = line_nt_mode; // (R12)
		end

		// ----------------------------------------
		// Message handling
		// ----------------------------------------
		case (r_reg.state)
			ST_IDLE: begin
				if (mon.rx_valid && mon.rx_byte[7:4] == MSG_REG_ACCESS) begin // (R1)
					r_next.addr = mon.rx_byte[3:0];
					if (mon.rx_byte[3:0] == MSG_READ_SUB) begin
						r_next.state = ST_RADDR; // (R2)
					end else begin
						r_next.state = ST_WDATA;
					end
				end
			end
			ST_WDATA: begin
				if (mon.rx_valid) begin
					r_next.state = ST_IDLE;
					case (r_reg.addr)
						ADDR_OPERATING_CONFIG: begin
							r_next.operating_config = mon.rx_byte;
						end
						ADDR_LOOPBACK_CONTROL: begin
							r_next.loopback_control = mon.rx_byte;
						end
						ADDR_CHANNEL_SWITCHING: begin
							r_next.channel_switching = mon.rx_byte;
						end
						default: begin
							r_next.state = ST_IDLE;
						end
					endcase
				end
			end
			ST_RADDR: begin
				if (mon.rx_valid) begin
					if (mon.rx_byte[7:4] == MSG_READ_UPPER) begin // (R2)
						r_next.addr = mon.rx_byte[3:0];
						r_next.tx_byte = {MSG_REG_ACCESS, mon.rx_byte[3:0]}; // (R3)
						r_next.tx_req = 1'b1;
						r_next.state = ST_RESP_HDR;
					end else begin
						r_next.state = ST_IDLE;
					end
				end
			end
			ST_RESP_HDR: begin
				if (mon.tx_ack) begin
					r_next.tx_byte = read_data; // (R3)
					r_next.state = ST_RESP_DATA;
				end
			end
			ST_RESP_DATA: begin
				if (mon.tx_ack) begin
					r_next.tx_req = 1'b0;
					r_next.state = ST_IDLE;
				end
			end
			default: begin
				r_next.tx_req = 1'b0;
				r_next.state = ST_IDLE;
			end
		endcase

		// ----------------------------------------
		// Decoded controls
		// ----------------------------------------
		r_next.mode = eff_mode;
		r_next.nt_sm = (strap_s == MODE_NT) ^ r_reg.operating_config[CFG_SM_SWAP]; // (R13)
		if (strap_s != MODE_NT && strap_s != MODE_LTS) begin
			r_next.nt_sm = 1'b0;
		end
		r_next.adaptive = line_nt_mode && r_reg.operating_config[CFG_MULTI_MEANING]; // (R6)
		r_next.wander50 = (eff_mode == MODE_LTT)
			&& r_reg.operating_config[CFG_MULTI_MEANING]; // (R7)
		r_next.clk16 = (eff_mode == MODE_TE)
			&& r_reg.operating_config[CFG_MULTI_MEANING]; // (R8)
		r_next.mf_en = !r_reg.operating_config[CFG_MF_DISABLE]; // (R15)
		r_next.sq_s2 = r_reg.operating_config[CFG_SQ_HANDLING] && r_next.mf_en; // (R9)
		r_next.lp = r_reg.operating_config[CFG_LOOP_TRANSP]; // (R12)
		r_next.lb1 = line_nt_mode && r_reg.loopback_control[LBK_LINE_B1]; // (R17)
		r_next.lb2 = line_nt_mode && r_reg.loopback_control[LBK_LINE_B2]; // (R17)
		// Registered mode makes the loop follow active_mode one cycle late across a mode change
		r_next.full = (r_reg.mode == MODE_LTS || r_reg.mode == MODE_NT)
			&& (r_reg.loopback_control[LBK_FULL_ANALOG] || analog_loop_command); // (R18)
		r_next.hb1 = r_reg.loopback_control[LBK_HOST_B1]; // (R19)
		r_next.hb2 = r_reg.loopback_control[LBK_HOST_B2]; // (R19)
		r_next.bswap = r_reg.loopback_control[LBK_B_SWAP]
			&& r_next.hb1 && r_next.hb2; // (R20)
		r_next.async_wake = r_reg.loopback_control[LBK_ASYNC_WAKE] && r_reg.nt_sm; // (R16)
		r_next.chs_out = r_reg.channel_switching; // (R21)
		if (r_reg.operating_config[CFG_AUX_PORT]) begin
			r_next.aux = AUX_MICRO; // (R14)
		end else begin
			r_next.aux = aux_io_variant ? AUX_IO_STANDARD : AUX_IO_SPECIFIC; // (R14)
		end

		// ----------------------------------------
		// Indications
		// ----------------------------------------
		r_next.cv_ind = code_violation_detected
			&& r_reg.operating_config[CFG_CV_REPORT]; // (R11)
		r_next.wander_ind = wander_exceeded && (r_reg.mode == MODE_LTT); // (R7)

		// S/Q reports only exist while multiframing runs
		if (multiframe_tick && r_reg.mf_en) begin
			if (r_reg.operating_config[CFG_SQ_HANDLING]) begin
				r_next.sq_report = 1'b1; // (R10)
			end else begin
				r_next.sq_report = (sq_rx_data != r_reg.sq_last); // (R9)
			end
			r_next.sq_last = sq_rx_data;
			r_next.sq_report_data = sq_rx_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			r_reg <= '0;
			r_reg.operating_config <= RST_OPERATING_CONFIG;
			r_reg.loopback_control <= RST_LOOPBACK_CONTROL;
			r_reg.channel_switching <= RST_CHANNEL_SWITCHING;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign active_mode = r_reg.mode;
	assign nt_state_machine = r_reg.nt_sm;
	assign adaptive_timing = r_reg.adaptive;
	assign wander_limit_50us = r_reg.wander50;
	assign conv_clk_16k = r_reg.clk16;
	assign sq_report = r_reg.sq_report;
	assign sq_report_data = r_reg.sq_report_data;
	assign sq_s2_available = r_reg.sq_s2;
	assign code_violation_indication = r_reg.cv_ind;
	assign wander_warning_indication = r_reg.wander_ind;
	assign loop_transparency = r_reg.lp;
	assign line_side_b1_loop = r_reg.lb1;
	assign line_side_b2_loop = r_reg.lb2;
	assign full_analog_loop = r_reg.full;
	assign host_side_b1_loop = r_reg.hb1;
	assign host_side_b2_loop = r_reg.hb2;
	assign b_channel_swap = r_reg.bswap;
	assign b1_relocate = r_reg.chs_out[CHS_B1_RELOC];
	assign b2_relocate = r_reg.chs_out[CHS_B2_RELOC];
	assign d_relocate = r_reg.chs_out[CHS_D_RELOC];
	assign b1_direction_swap = r_reg.chs_out[CHS_B1_DIR]; // (R22)
	assign b2_direction_swap = r_reg.chs_out[CHS_B2_DIR]; // (R22)
	assign command_channel_handling = r_reg.chs_out[CHS_CMD_HANDLING]; // (R23)
	assign d_access_protocol = r_reg.chs_out[CHS_D_PROTO_LSB +: 2]; // (R24)
	assign aux_port_mode = r_reg.aux;
	assign async_wakeup_timing = r_reg.async_wake;
	assign multiframe_enable = r_reg.mf_en;
endmodule : stmr_regs

// [sim/stmr_regs_sva.sv]
`timescale 1ns/1ps
module stmr_regs_sva (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic host_data_out_oe,
	input wire stmr_pkg::stmr_mode_t strap_mode,
	input wire logic mode_strap_pin,
	input wire logic analog_loop_command,
	input wire logic code_violation_detected,
	input wire logic wander_exceeded,
	input wire logic multiframe_tick,
	input wire stmr_pkg::stmr_mode_t active_mode,
	input wire logic nt_state_machine,
	input wire logic code_violation_indication,
	input wire logic wander_warning_indication,
	input wire logic sq_report,
	input wire logic multiframe_enable,
	input wire logic full_analog_loop,
	input wire logic host_side_b1_loop,
	input wire logic host_side_b2_loop,
	input wire logic b_channel_swap,
	input wire logic async_wakeup_timing
);
	import stmr_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// ----------------------------------------
	// Multi-step behaviour
	// ----------------------------------------
	// Six steady samples cover the strap synchronisers plus decode
	sequence s_lts_strapped;
		(strap_mode == MODE_LTS && !mode_strap_pin) [*6];
	endsequence
	// A monitor slot is nine link bits, far longer than eight clocks
	sequence s_oe_held;
		host_data_out_oe [*8];
	endsequence
	a_strap_honour: assert property (s_lts_strapped |-> active_mode == MODE_LTS)
		else $error("mode left line termination with strap pin low");
	a_oe_slot_hold: assert property ($rose(host_data_out_oe) |-> s_oe_held)
		else $error("output enable dropped inside the monitor slot");
	a_cv_cause: assert property (code_violation_indication |-> $past(code_violation_detected))
		else $error("violation indication without a detected violation");
	a_wander_cause: assert property (wander_warning_indication |-> $past(wander_exceeded)
		&& $past(active_mode) == MODE_LTT)
		else $error("wander warning without cause or outside trunk mode");
	a_sq_tick: assert property (sq_report |-> $past(multiframe_tick) && $past(multiframe_enable))
		else $error("s/q report without multiframe tick or with multiframing off");
	a_analog_cmd: assert property ((analog_loop_command
		&& active_mode inside {MODE_LTS, MODE_NT}) |=> full_analog_loop)
		else $error("analog loop command did not close the full loop");
	a_b_swap_both: assert property (b_channel_swap |-> host_side_b1_loop && host_side_b2_loop)
		else $error("b swap active without both host loops");
	a_async_nt: assert property (async_wakeup_timing |-> $past(nt_state_machine))
		else $error("async wake-up without network state machine");
endmodule : stmr_regs_sva

bind stmr_regs stmr_regs_sva u_sva (.clk_sys, .rstn, .host_data_out_oe, .strap_mode,
	.mode_strap_pin, .analog_loop_command, .code_violation_detected, .wander_exceeded,
	.multiframe_tick, .active_mode, .nt_state_machine, .code_violation_indication,
	.wander_warning_indication, .sq_report, .multiframe_enable, .full_analog_loop,
	.host_side_b1_loop, .host_side_b2_loop, .b_channel_swap, .async_wakeup_timing);

// [sim/stmr_host_model.sv]
`timescale 1ns/1ps
module stmr_host_model (
	output logic dcl,
	output logic fsc,
	output logic host_data_in_pin,
	input wire logic host_data_out_pin,
	input wire logic host_data_out_oe
);
	import stmr_pkg::*;
	// Released device pin reads high through its pull-up
	wire line_level = host_data_out_oe ? host_data_out_pin : 1'b1;
	initial begin
		dcl = 1'b0;
		fsc = 1'b0;
		host_data_in_pin = 1'b1;
	end
	// ----------------------------------------
	// Frame: 32 bits, monitor byte in bits 16..23, valid low in bit 24
	// ----------------------------------------
	// Link clock stands still between frames
	task automatic frame(input logic [7:0] tx, input logic tx_valid, output logic [7:0] rx,
		output logic rx_valid);
		logic [31:0] seen;
		for (int b = 0; b < 32; b++) begin
			fsc = (b == 0);
			host_data_in_pin = (b >= 16 && b <= 23) ? tx[23 - b] : (b == 24) ? !tx_valid : 1'b1;
			#80 dcl = 1'b1;
			#80 dcl = 1'b0;
			#40 seen = {seen[30:0], line_level};
			#40 dcl = 1'b1;
			#80 dcl = 1'b0;
		end
		rx = seen[15:8];
		rx_valid = !seen[7];
	endtask : frame
	task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic v;
		frame({MSG_REG_ACCESS, a}, 1'b1, r, v);
		frame(d, 1'b1, r, v);
	endtask : write_reg
	// Host stays silent while the two answer bytes come back
	task automatic read_reg(input logic [3:0] a, output logic [7:0] h, output logic hv,
		output logic [7:0] d, output logic dv);
		logic [7:0] r;
		logic v;
		frame({MSG_REG_ACCESS, MSG_READ_UPPER}, 1'b1, r, v);
		frame({MSG_READ_SUB, a}, 1'b1, r, v);
		frame(8'hFF, 1'b0, h, hv);
		frame(8'hFF, 1'b0, d, dv);
	endtask : read_reg
endmodule : stmr_host_model

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import stmr_pkg::*;
	localparam logic [7:0] VERSION = 8'hC3; // Arbitrary code for this bench
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic dcl, fsc, host_data_in_pin, host_data_out_pin, host_data_out_oe;
	stmr_mode_t strap_mode = MODE_LTS;
	logic mode_strap_pin = 1'b0;
	logic mf_sync_established = 1'b0;
	logic analog_loop_command = 1'b0;
	logic aux_io_variant = 1'b0;
	logic [2:0] stim = 3'h0;
	logic [3:0] sq_rx_data = 4'h0;
	stmr_mode_t active_mode;
	stmr_aux_t aux_port_mode;
	logic nt_state_machine, adaptive_timing, wander_limit_50us, conv_clk_16k, sq_report;
	logic sq_s2_available, code_violation_indication, wander_warning_indication;
	logic loop_transparency, line_side_b1_loop, line_side_b2_loop, full_analog_loop;
	logic host_side_b1_loop, host_side_b2_loop, b_channel_swap, b1_relocate, b2_relocate;
	logic d_relocate, b1_direction_swap, b2_direction_swap, command_channel_handling;
	logic async_wakeup_timing, multiframe_enable;
	logic [3:0] sq_report_data;
	logic [1:0] d_access_protocol;
	logic [2:0] pulses;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	assign pulses = {sq_report, code_violation_indication, wander_warning_indication};
	always #4 clk_sys = ~clk_sys;
	stmr_host_model host (.dcl, .fsc, .host_data_in_pin, .host_data_out_pin, .host_data_out_oe);
	stmr_regs #(.VERSION_CODE(VERSION)) DUT (.clk_sys, .rstn, .dcl, .fsc, .host_data_in_pin,
		.host_data_out_pin, .host_data_out_oe, .strap_mode, .mode_strap_pin,
		.mf_sync_established, .analog_loop_command, .aux_io_variant,
		.code_violation_detected(stim[1]), .wander_exceeded(stim[0]), .sq_rx_data,
		.multiframe_tick(stim[2]), .active_mode, .nt_state_machine, .adaptive_timing,
		.wander_limit_50us, .conv_clk_16k, .sq_report, .sq_report_data, .sq_s2_available,
		.code_violation_indication, .wander_warning_indication, .loop_transparency,
		.line_side_b1_loop, .line_side_b2_loop, .full_analog_loop, .host_side_b1_loop,
		.host_side_b2_loop, .b_channel_swap, .b1_relocate, .b2_relocate, .d_relocate,
		.b1_direction_swap, .b2_direction_swap, .command_channel_handling, .d_access_protocol,
		.aux_port_mode, .async_wakeup_timing, .multiframe_enable);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic stop_test();
		if (mismatches == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] h, d;
		logic hv, dv;
		host.read_reg(a, h, hv, d, dv);
		check("read header", {MSG_REG_ACCESS, a}, h);
		check("read data", exp, d);
		check("read valid", 8'h03, {6'h00, hv, dv});
	endtask : rd
	// Pulses an event input and looks for its indication a few cycles on
	task automatic fire(input int i, input logic want, input string what);
		logic seen;
		seen = 1'b0;
		@(negedge clk_sys);
		stim[i] = 1'b1;
		repeat (4) begin
			@(negedge clk_sys);
			stim[i] = 1'b0;
			seen = seen | pulses[i];
		end
		check(what, {7'h00, want}, {7'h00, seen});
	endtask : fire
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset();
		check("strap outputs", 8'h0B, {4'h0, loop_transparency, nt_state_machine, active_mode});
		rd(ADDR_VERSION_ID, VERSION);
		rd(ADDR_OPERATING_CONFIG, 8'h08);
		rd(ADDR_LOOPBACK_CONTROL, RST_LOOPBACK_CONTROL);
		rd(ADDR_CHANNEL_SWITCHING, RST_CHANNEL_SWITCHING);
	endtask : test_reset
	task automatic test_regs();
		@(negedge clk_sys);
		mf_sync_established = 1'b1;
		host.write_reg(ADDR_OPERATING_CONFIG, 8'h34);
		check("config outputs", 8'h0D, {4'h0, nt_state_machine, multiframe_enable,
			loop_transparency, sq_s2_available});
		rd(ADDR_OPERATING_CONFIG, 8'h35);
		host.write_reg(ADDR_LOOPBACK_CONTROL, 8'h8F);
		check("loop outputs", 8'h8E, {async_wakeup_timing, line_side_b1_loop,
			line_side_b2_loop, full_analog_loop, host_side_b1_loop, host_side_b2_loop,
			b_channel_swap, 1'b0});
		rd(ADDR_LOOPBACK_CONTROL, 8'h8F);
		host.write_reg(ADDR_CHANNEL_SWITCHING, 8'hE6);
		check("channel outputs", 8'hE6, {b1_relocate, b2_relocate, d_relocate,
			b1_direction_swap, b2_direction_swap, command_channel_handling, d_access_protocol});
		rd(ADDR_CHANNEL_SWITCHING, 8'hE6);
		host.write_reg(ADDR_VERSION_ID, 8'hFF);
		rd(ADDR_VERSION_ID, VERSION);
		host.write_reg(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
	endtask : test_regs
	task automatic test_events();
		@(negedge clk_sys);
		sq_rx_data = 4'hA;
		fire(2, 1'b1, "s/q report");
		check("s/q data", 8'h0A, {4'h0, sq_report_data});
		fire(2, 1'b1, "unchanged s/q report");
		fire(1, 1'b1, "violation indication");
		analog_loop_command = 1'b1;
		repeat (3) @(negedge clk_sys);
		check("analog loop", 8'h01, {7'h00, full_analog_loop});
		analog_loop_command = 1'b0;
		host.write_reg(ADDR_OPERATING_CONFIG, 8'h00);
		fire(2, 1'b0, "non-auto unchanged s/q");
		sq_rx_data = 4'h5;
		fire(2, 1'b1, "non-auto changed s/q");
		host.write_reg(ADDR_OPERATING_CONFIG, 8'h01);
		check("s2 in non-auto", 8'h00, {7'h00, sq_s2_available});
		fire(2, 1'b0, "report with multiframing off");
		fire(1, 1'b0, "violation with reporting off");
	endtask : test_events
	task automatic test_strap();
		@(negedge clk_sys);
		mode_strap_pin = 1'b1;
		host.write_reg(ADDR_OPERATING_CONFIG, 8'hC0);
		check("trunk outputs", 8'h06, {4'h0, adaptive_timing, wander_limit_50us, active_mode});
		fire(0, 1'b1, "wander warning");
		aux_io_variant = 1'b1;
		host.write_reg(ADDR_OPERATING_CONFIG, 8'h40);
		host.write_reg(ADDR_LOOPBACK_CONTROL, 8'h70);
		check("line outputs", 8'h2D, {2'h0, adaptive_timing, conv_clk_16k,
			active_mode, aux_port_mode});
		check("line loops", 8'h07, {5'h00, line_side_b1_loop, line_side_b2_loop,
			full_analog_loop});
		strap_mode = MODE_TE;
		host.write_reg(ADDR_OPERATING_CONFIG, 8'h42);
		check("terminal outputs", 8'h12, {2'h0, adaptive_timing, conv_clk_16k,
			active_mode, aux_port_mode});
	endtask : test_strap
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 90000) begin
			mismatches++;
			stop_test();
		end
	end
	initial begin
		repeat (5) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (10) @(negedge clk_sys);
		test_reset();
		test_regs();
		test_events();
		test_strap();
		stop_test();
	end
endmodule : testbench
